// *** common/rtci_pkg.sv ***
// constants and types of the two-wire target port of the clock module
// assumes one 10 MHz clock domain; the register bank itself sits outside the port
`default_nettype none

package rtci_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h68;
    localparam int PTR_W = 4;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_PTR,
        S_WDATA,
        S_ACK,
        S_RDATA,
        S_RACK,
        S_IGNORE
    } rtci_state_t;

    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rtci_wr_t;
endpackage

`default_nettype wire

// *** core/rtci_fifo.sv ***
// small synchronous FIFO with valid/ready on both sides
// assumes both sides on clk_i; ce_i low freezes all state
`default_nettype none

module rtci_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_ff [D];
    logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready_o = (cnt_ff != (AW+1)'(D));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rp_ff];

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        nxt_wp = push ? ((wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1) : wp_ff;
        nxt_rp = pop ? ((rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1) : rp_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else if (ce_i) begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            if (push) begin
                mem_ff[wp_ff] <= in_data_i;
            end
        end
    end
endmodule

`default_nettype wire

// *** core/rtci_slave.sv ***
// two-wire target port: start/stop detection, addressing, pointer, byte moves
// assumes scl/sda arrive unsynchronised from pins; register bank on clk_i
`default_nettype none

module rtci_slave (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // register write stream
    output rtci_pkg::rtci_wr_t wr_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    // register read port
    output logic [3:0] rd_addr_o,
    output logic rd_strobe_o,
    input wire logic [7:0] rd_data_i,
    // status
    output logic busy_o
);
    function automatic logic [3:0] inc_ptr(input logic [3:0] p);
        inc_ptr = p + 4'h1;
    endfunction

    // pin synchronisers and edge history
    logic scl_m_ff, scl_s_ff, scl_d_ff, sda_m_ff, sda_s_ff, sda_d_ff;
    logic nxt_scl_m, nxt_scl_s, nxt_scl_d, nxt_sda_m, nxt_sda_s, nxt_sda_d;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        nxt_scl_m = scl_i;
        nxt_scl_s = scl_m_ff;
        nxt_scl_d = scl_s_ff;
        nxt_sda_m = sda_i;
        nxt_sda_s = sda_m_ff;
        nxt_sda_d = sda_s_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            scl_d_ff <= 1'b1;
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else if (ce_i) begin
            scl_m_ff <= nxt_scl_m;
            scl_s_ff <= nxt_scl_s;
            scl_d_ff <= nxt_scl_d;
            sda_m_ff <= nxt_sda_m;
            sda_s_ff <= nxt_sda_s;
            sda_d_ff <= nxt_sda_d;
        end
    end

    assign scl_rise = scl_s_ff && !scl_d_ff;
    assign scl_fall = !scl_s_ff && scl_d_ff;
    // both samples high keeps a data change near the clock edge from posing as start
    assign start_det = scl_s_ff && scl_d_ff && sda_d_ff && !sda_s_ff;
    assign stop_det = scl_s_ff && scl_d_ff && !sda_d_ff && sda_s_ff;

    // protocol state
    rtci_pkg::rtci_state_t state_ff, nxt_state, ret_ff, nxt_ret;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic full_ff, nxt_full;
    logic [3:0] ptr_ff, nxt_ptr;
    logic ack_ff, nxt_ack;
    logic oe_ff, nxt_oe;
    logic strobe_ff, nxt_strobe;
    logic push_valid, push_ready;
    rtci_pkg::rtci_wr_t push_data;

    always_comb begin
        nxt_state = state_ff;
        nxt_ret = ret_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_full = full_ff;
        nxt_ptr = ptr_ff;
        nxt_ack = ack_ff;
        nxt_oe = oe_ff;
        nxt_strobe = 1'b0;
        push_valid = 1'b0;
        push_data = '{addr: ptr_ff, data: shift_ff};
        if (start_det) begin
            // a start always restarts addressing, ending any write in flight
            nxt_state = rtci_pkg::S_ADDR;
            nxt_cnt = rtci_pkg::BIT_FIRST;
            nxt_full = 1'b0;
            nxt_oe = 1'b0;
        end else if (stop_det) begin
            nxt_state = rtci_pkg::S_IDLE;
            nxt_full = 1'b0;
            nxt_oe = 1'b0;
        end else begin
            case (state_ff)
                rtci_pkg::S_ADDR, rtci_pkg::S_PTR, rtci_pkg::S_WDATA: begin
                    if (scl_rise && !full_ff) begin
                        nxt_shift = {shift_ff[6:0], sda_s_ff};
                        nxt_cnt = cnt_ff + 3'h1;
                        nxt_full = (cnt_ff == rtci_pkg::BIT_LAST);
                    end else if (scl_fall && full_ff) begin
                        nxt_full = 1'b0;
                        nxt_state = rtci_pkg::S_ACK;
                        nxt_ack = 1'b1;
                        case (state_ff)
                            rtci_pkg::S_ADDR: begin
                                if (shift_ff[7:1] == rtci_pkg::DEV_ADDR) begin
                                    nxt_ret = shift_ff[0] ? rtci_pkg::S_RDATA
                                                          : rtci_pkg::S_PTR;
                                end else begin
                                    nxt_state = rtci_pkg::S_IGNORE;
                                    nxt_ack = 1'b0;
                                end
                            end
                            rtci_pkg::S_PTR: begin
                                nxt_ptr = shift_ff[3:0];
                                nxt_ret = rtci_pkg::S_WDATA;
                            end
                            default: begin
                                // no clock stretching: a full buffer can only refuse
                                push_valid = 1'b1;
                                nxt_ret = rtci_pkg::S_WDATA;
                                if (push_ready) begin
                                    nxt_ptr = inc_ptr(ptr_ff);
                                end else begin
                                    nxt_ack = 1'b0;
                                end
                            end
                        endcase
                        nxt_oe = nxt_ack;
                    end
                end
                rtci_pkg::S_ACK: begin
                    if (scl_fall) begin
                        nxt_state = ret_ff;
                        nxt_cnt = rtci_pkg::BIT_FIRST;
                        nxt_oe = 1'b0;
                        if (ret_ff == rtci_pkg::S_RDATA) begin
                            nxt_shift = rd_data_i;
                            nxt_oe = !rd_data_i[7];
                            nxt_strobe = 1'b1;
                        end
                    end
                end
                rtci_pkg::S_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_ff == rtci_pkg::BIT_LAST) begin
                            nxt_state = rtci_pkg::S_RACK;
                            nxt_oe = 1'b0;
                            nxt_ptr = inc_ptr(ptr_ff);
                            nxt_cnt = rtci_pkg::BIT_FIRST;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_cnt = cnt_ff + 3'h1;
                            nxt_oe = !shift_ff[6];
                        end
                    end
                end
                rtci_pkg::S_RACK: begin
                    if (scl_rise) begin
                        nxt_ack = !sda_s_ff;
                    end else if (scl_fall) begin
                        if (ack_ff) begin
                            nxt_state = rtci_pkg::S_RDATA;
                            nxt_shift = rd_data_i;
                            nxt_oe = !rd_data_i[7];
                            nxt_strobe = 1'b1;
                        end else begin
                            nxt_state = rtci_pkg::S_IGNORE;
                            nxt_oe = 1'b0;
                        end
                    end
                end
                rtci_pkg::S_IGNORE: begin
                    nxt_oe = 1'b0;
                end
                default: begin
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= rtci_pkg::S_IDLE;
            ret_ff <= rtci_pkg::S_IDLE;
            cnt_ff <= rtci_pkg::BIT_FIRST;
            shift_ff <= 8'h00;
            full_ff <= 1'b0;
            ptr_ff <= rtci_pkg::PTR_RST;
            ack_ff <= 1'b0;
            oe_ff <= 1'b0;
            strobe_ff <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            ret_ff <= nxt_ret;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            full_ff <= nxt_full;
            ptr_ff <= nxt_ptr;
            ack_ff <= nxt_ack;
            oe_ff <= nxt_oe;
            strobe_ff <= nxt_strobe;
        end
    end

    // open-drain: the line is only ever pulled low, never driven high
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_ff;
    assign rd_addr_o = ptr_ff;
    assign rd_strobe_o = strobe_ff;
    assign busy_o = (state_ff != rtci_pkg::S_IDLE);

    rtci_fifo #(
        .W($bits(rtci_pkg::rtci_wr_t)),
        .D(rtci_pkg::FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_data),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(wr_o)
    );

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence seq_addr_hit;
        ce_i && state_ff == rtci_pkg::S_ADDR && scl_fall && full_ff && !start_det
            && !stop_det && shift_ff[7:1] == rtci_pkg::DEV_ADDR;
    endsequence

    sequence seq_addr_miss;
        ce_i && state_ff == rtci_pkg::S_ADDR && scl_fall && full_ff && !start_det
            && !stop_det && shift_ff[7:1] != rtci_pkg::DEV_ADDR;
    endsequence

    // the master's answer is latched at the clock rise and acted on at the fall
    sequence seq_master_nack;
        ce_i && state_ff == rtci_pkg::S_RACK && scl_fall && !ack_ff && !start_det
            && !stop_det;
    endsequence

    sequence seq_master_ack;
        ce_i && state_ff == rtci_pkg::S_RACK && scl_fall && ack_ff && !start_det
            && !stop_det;
    endsequence

    sequence seq_first_load;
        ce_i && state_ff == rtci_pkg::S_ACK && ret_ff == rtci_pkg::S_RDATA && scl_fall
            && !start_det && !stop_det;
    endsequence

    // checks watch the synced pins, so they trail the real bus by two to three clocks
    chk_addr_ack: assert property (seq_addr_hit |=> state_ff == rtci_pkg::S_ACK && sda_oe_o)
        else $error("matching address not acknowledged");
    chk_addr_miss: assert property (seq_addr_miss |=>
        state_ff == rtci_pkg::S_IGNORE && !sda_oe_o)
        else $error("foreign address acknowledged");
    chk_ignore_release: assert property (state_ff == rtci_pkg::S_IGNORE |-> !sda_oe_o)
        else $error("data line driven while ignoring");
    chk_ack_hold: assert property (state_ff == rtci_pkg::S_ACK && ack_ff && scl_s_ff
        |-> sda_oe_o)
        else $error("ack released during clock high");
    chk_rack_free: assert property (state_ff == rtci_pkg::S_RACK |-> !sda_oe_o)
        else $error("data line driven in master ack slot");
    chk_nack_release: assert property (seq_master_nack |=>
        !sda_oe_o && state_ff == rtci_pkg::S_IGNORE)
        else $error("data line held after master nack");
    chk_read_first: assert property (seq_first_load |=> rd_strobe_o
        && shift_ff == $past(rd_data_i) && sda_oe_o == !shift_ff[7])
        else $error("first read byte not loaded from pointer");
    chk_read_reload: assert property (seq_master_ack |=> state_ff == rtci_pkg::S_RDATA
        && rd_strobe_o && shift_ff == $past(rd_data_i))
        else $error("next read byte not loaded after master ack");
    chk_ptr_load: assert property (ce_i && state_ff == rtci_pkg::S_PTR && scl_fall
        && full_ff && !start_det && !stop_det |=> ptr_ff == shift_ff[3:0])
        else $error("pointer not loaded from low nibble");
    chk_ptr_step: assert property (ce_i && push_valid && push_ready
        |=> ptr_ff == inc_ptr($past(ptr_ff)) && wr_valid_o)
        else $error("pointer not advanced after stored byte");
    chk_full_nack: assert property (ce_i && push_valid && !push_ready
        |=> !sda_oe_o && $stable(ptr_ff))
        else $error("refused byte acknowledged or pointer moved");
    chk_tx_bit: assert property (state_ff == rtci_pkg::S_RDATA |-> sda_oe_o == !shift_ff[7])
        else $error("transmitted bit mismatch");
    chk_start_addr: assert property (ce_i && start_det |=> state_ff == rtci_pkg::S_ADDR
        && !sda_oe_o)
        else $error("start did not restart addressing");
    chk_stop_idle: assert property (ce_i && stop_det && !start_det
        |=> state_ff == rtci_pkg::S_IDLE && !sda_oe_o)
        else $error("stop did not return to idle");
    chk_sda_only_low: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data line driven high");
endmodule

`default_nettype wire

// *** test/rtci_master.sv ***
// behavioural bus master driving the two-wire port of the clock module
// assumes the bench resolves the open-drain data line with a pull-up; steps on clk_i falls
`default_nettype none

module rtci_master (
    // timing reference
    input wire logic clk_i,
    // bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // both lines idle high; the clock only runs inside frames
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // one bit period of 8 clocks: data set mid-low, line sampled mid-high
    task automatic pulse(input logic drive_low, output logic seen);
        tick(2);
        sda_oe_o = drive_low;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        seen = sda_i;
        tick(2);
        scl_o = 1'b0;
    endtask

    task automatic start_c();
        sda_oe_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
    endtask

    // stop also separates transfers, though a start alone also serves a direction change
    task automatic stop_c();
        tick(2);
        sda_oe_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b0;
        tick(4);
    endtask

    // start with no stop before it, used only to test the write ending
    task automatic rstart_c();
        tick(2);
        sda_oe_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        start_c();
    endtask

    // msb first, then one clock for the receiver's ack
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(!b[i], s);
        end
        pulse(1'b0, s);
        ack = !s;
    endtask

    // line left released during data; ack low to continue, released to end
    task automatic recv(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            pulse(1'b0, b[i]);
        end
        pulse(ack, s);
    endtask
endmodule

`default_nettype wire

// *** test/tb.sv ***
// self-checking bench of the two-wire target port with a register stand-in
// assumes a master model on the bus and a bench-held write sink and read source
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i, rst_i, ce_i, scl, m_oe, sda, sda_o, sda_oe_o;
    logic wr_valid_o, wr_ready_i, rd_strobe_o, busy_o;
    logic [3:0] rd_addr_o;
    logic [7:0] rd_data_i;
    rtci_pkg::rtci_wr_t wr_o;
    rtci_pkg::rtci_wr_t got[$];
    int err_count = 0;
    int compares = 0;
    int n_strobe = 0;
    localparam logic [7:0] BAD [4] = '{8'hd2, 8'h50, 8'hd8, 8'h68};

    function automatic logic [7:0] rdv(input logic [3:0] a);
        return {a, ~a};
    endfunction

    // wired-and with pull-up: released line reads high
    assign sda = !(m_oe || (sda_oe_o && !sda_o));
    assign rd_data_i = rdv(rd_addr_o);

    rtci_slave i_rtci_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_o(wr_o),
        .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .rd_addr_o(rd_addr_o),
        .rd_strobe_o(rd_strobe_o), .rd_data_i(rd_data_i), .busy_o(busy_o));
    rtci_master i_rtci_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) got.push_back(wr_o);
        if (rd_strobe_o === 1'b1) n_strobe++;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic drain(input int n);
        for (int k = 0; k < 40 && got.size() < n; k++) @(negedge clk_i);
        if (got.size() < n) begin
            err_count++;
            print_verdict();
        end
    endtask

    // idle after reset; with the enable low a start and a stop with no bytes pass unseen
    task automatic t_freeze();
        chk(sda_oe_o, 1'b0);
        chk(busy_o, 1'b0);
        ce_i = 1'b0;
        i_rtci_master.start_c();
        i_rtci_master.tick(4);
        chk(busy_o, 1'b0);
        i_rtci_master.stop_c();
        ce_i = 1'b1;
        i_rtci_master.tick(4);
        chk(busy_o, 1'b0);
        chk(sda_oe_o, 1'b0);
        $display("test freeze done");
    endtask

    // 9 bytes into a stalled 8-deep sink: last is refused, pointer wraps
    task automatic t_write_fill();
        logic a;
        got.delete();
        i_rtci_master.start_c();
        i_rtci_master.send(8'hd0, a);
        chk(a, 1'b1);
        i_rtci_master.send(8'hfc, a);
        chk(a, 1'b1);
        for (int i = 0; i < 9; i++) begin
            i_rtci_master.send(8'h30 + i[7:0], a);
            chk(a, i < 8);
        end
        chk(busy_o, 1'b1);
        i_rtci_master.stop_c();
        chk(wr_valid_o, 1'b1);
        wr_ready_i = 1'b1;
        drain(8);
        wr_ready_i = 1'b0;
        for (int i = 0; i < 8; i++) begin
            chk(got[i].addr, 4'(4'hc + i));
            chk(got[i].data, 8'h30 + i[7:0]);
        end
        chk(rd_addr_o, 4'h4);
        $display("test write_fill done");
    endtask

    // read with no pointer write continues after the last register
    task automatic t_read_next();
        logic a;
        logic [7:0] b;
        int s0;
        s0 = n_strobe;
        i_rtci_master.start_c();
        i_rtci_master.send(8'hd1, a);
        chk(a, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_rtci_master.recv(i < 2, b);
            chk(b, rdv(4'(4 + i)));
        end
        i_rtci_master.tick(4);
        chk(sda_oe_o, 1'b0);
        i_rtci_master.stop_c();
        chk(16'(n_strobe - s0), 16'h3);
        chk(rd_addr_o, 4'h7);
        $display("test read_next done");
    endtask

    // pointer set, stop, start, read across the wrap
    task automatic t_read_at();
        logic a;
        logic [7:0] b;
        i_rtci_master.start_c();
        i_rtci_master.send(8'hd0, a);
        i_rtci_master.send(8'h0f, a);
        chk(a, 1'b1);
        i_rtci_master.stop_c();
        i_rtci_master.start_c();
        i_rtci_master.send(8'hd1, a);
        chk(a, 1'b1);
        i_rtci_master.recv(1'b1, b);
        chk(b, rdv(4'hf));
        i_rtci_master.recv(1'b0, b);
        chk(b, rdv(4'h0));
        i_rtci_master.stop_c();
        chk(rd_addr_o, 4'h1);
        $display("test read_at done");
    endtask

    // a start in mid-write closes the first transfer and opens a second
    task automatic t_restart();
        logic a;
        got.delete();
        wr_ready_i = 1'b1;
        i_rtci_master.start_c();
        i_rtci_master.send(8'hd0, a);
        i_rtci_master.send(8'h02, a);
        i_rtci_master.send(8'h5a, a);
        i_rtci_master.rstart_c();
        i_rtci_master.send(8'hd0, a);
        chk(a, 1'b1);
        i_rtci_master.send(8'h05, a);
        i_rtci_master.send(8'ha5, a);
        i_rtci_master.stop_c();
        drain(2);
        wr_ready_i = 1'b0;
        chk(got[0], {4'h2, 8'h5a});
        chk(got[1], {4'h5, 8'ha5});
        $display("test restart done");
    endtask

    // foreign addresses get no ack and the line stays released
    task automatic t_bad_addr();
        logic a;
        for (int i = 0; i < 4; i++) begin
            i_rtci_master.start_c();
            i_rtci_master.send(BAD[i], a);
            chk(a, 1'b0);
            i_rtci_master.send(8'h00, a);
            chk(a, 1'b0);
            i_rtci_master.stop_c();
        end
        chk(sda_o, 1'b0);
        $display("test bad_addr done");
    endtask

    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end

    initial begin
        ce_i = 1'b1;
        rst_i = 1'b1;
        wr_ready_i = 1'b0;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        t_freeze();
        t_write_fill();
        t_read_next();
        t_read_at();
        t_restart();
        t_bad_addr();
        print_verdict();
    end
endmodule

`default_nettype wire
